// ### hw/dtc_pkg.sv
// Package with register map, field layout and timing constants of the dual timer/counter.
// Function
// [R1] Count only when running and gate allows
// [R2] Count source picks pin edges or cycles
// [R3] Mode field selects one of four modes
// [R4] Mode 0 is 13-bit, rollover sets flag
// [R5] Mode 0 uses high byte over low five
// [R6] Upper three low bits undefined in mode 0
// [R7] Setting run bit keeps the stored count
// [R8] Gate select at bit 7 and bit 3
// [R9] Overflow flag serves as interrupt request
// [R10] Mode 1 counts all sixteen bits
// [R11] Mode 2 reloads low byte from high
// [R12] Reload leaves the high byte untouched
// [R13] Unit 1 in mode 3 holds its count
// [R14] Unit 0 mode 3 low byte separate counter
// [R15] Unit 0 mode 3 high byte uses unit 1
// [R16] Unit 1 stops via its own mode 3
// [R17] Unit 1 still overflows for baud use
// [R18] Mode configuration resets to zero
// [R19] Machine cycle lasts six oscillator periods
// [R20] Pin sampled per cycle, falling edge counts
// [R21] Flags set on overflow, cleared on vector
// [R22] Run bits switch the units on and off
// [R23] Unit 1 fields high nibble, unit 0 low
package dtc_pkg;

  // Register offsets on the register port.
  localparam logic [7:0] RUN_FLAG_OFS = 8'h88;
  localparam logic [7:0] MODE_CFG_OFS = 8'h89;
  localparam logic [7:0] LOW0_OFS = 8'h8A;
  localparam logic [7:0] LOW1_OFS = 8'h8B;
  localparam logic [7:0] HIGH0_OFS = 8'h8C;
  localparam logic [7:0] HIGH1_OFS = 8'h8D;

  // Reset values.
  localparam logic [7:0] MODE_CFG_RST = 8'h00;
  localparam logic [7:0] RUN_FLAG_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;

  // Field positions in the run/flag register.
  localparam int FLAG1_BIT = 7;
  localparam int RUN1_BIT = 6;
  localparam int FLAG0_BIT = 5;
  localparam int RUN0_BIT = 4;

  // Field positions inside one mode nibble.
  localparam int GATE_BIT = 3;
  localparam int SRC_BIT = 2;
  localparam int MODE_HI_BIT = 1;
  localparam int MODE_LO_BIT = 0;
  // Nibble base of each unit in the mode configuration register.
  localparam int UNIT1_BASE = 4;
  localparam int UNIT0_BASE = 0;

  // Mode field encodings.
  localparam logic [1:0] MODE_13BIT = 2'h0;
  localparam logic [1:0] MODE_16BIT = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;

  // Oscillator periods per machine cycle.
  localparam int MC_OSC_PERIODS = 6;

endpackage

// ### hw/dtc_top.sv
// Two 16-bit timer/counters with a shared mode register and a plain register port.
//
// Design decision made here: the strobed register port.
`timescale 1ns/100ps

module dtc_top #(
  parameter int MC_DIV = dtc_pkg::MC_OSC_PERIODS
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic count_pin_unit0,
  input wire logic count_pin_unit1,
  input wire logic gate_pin_unit0,
  input wire logic gate_pin_unit1,
  input wire logic irq_ack_unit0,
  input wire logic irq_ack_unit1,
  output logic irq_req_unit0,
  output logic irq_req_unit1,
  output logic baud_tick_unit1
);

  // Advance function: returns {overflow, high, low} for one count step.
  // Mode 3 holds, which is what unit 1 needs; unit 0 mode 3 is handled apart.
  function automatic logic [16:0] step(
    input logic [1:0] mode,
    input logic [7:0] hi,
    input logic [7:0] lo
  );
    logic [13:0] v13;
    logic [16:0] v16;
    logic [8:0] v8;
    begin
      v13 = {1'b0, hi, lo[4:0]} + 14'h0001;
      v16 = {1'b0, hi, lo} + 17'h00001;
      v8 = {1'b0, lo} + 9'h001;
      unique case (mode)
        dtc_pkg::MODE_13BIT: begin
          // Upper three low bits just keep their value. [R6]
          step = {v13[13], v13[12:5], lo[7:5], v13[4:0]}; // [R4] [R5]
        end
        dtc_pkg::MODE_16BIT: begin
          step = v16; // [R10]
        end
        dtc_pkg::MODE_RELOAD: begin
          // Reload from high byte, high byte itself untouched. [R12]
          step = {v8[8], hi, (v8[8] ? hi : v8[7:0])}; // [R11]
        end
        dtc_pkg::MODE_SPLIT: begin
          // Unit 1 in mode 3 holds both bytes and never overflows, as if its
          // run bit were clear; the split case of unit 0 bypasses this path.
          step = {1'b0, hi, lo}; // [R13]
        end
      endcase
    end
  endfunction

  // Mode configuration register.
  logic [7:0] mode_cfg_q;
  // Run bits and overflow flags.
  logic run0_q;
  logic run1_q;
  logic flag0_q;
  logic flag1_q;
  // Count bytes.
  logic [7:0] lo0_q;
  logic [7:0] hi0_q;
  logic [7:0] lo1_q;
  logic [7:0] hi1_q;
  // Registered read data and baud pulse.
  logic [7:0] rdata_q;
  logic baud_q;

  // Machine cycle divider.
  logic [7:0] mc_cnt_q;
  logic mc_tick;

  // Two-flop synchronisers for the four pins.
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  // Count pin sample from the previous machine cycle.
  logic [1:0] cnt_prev_q;

  // Decoded fields, named per unit.
  logic gate0;
  logic gate1;
  logic src0;
  logic src1;
  logic [1:0] mode0;
  logic [1:0] mode1;
  logic split0;

  // Count enables and overflow events.
  logic inc0;
  logic inc1;
  logic inc_hi0;
  logic [1:0] fall;
  logic [16:0] nxt0;
  logic [16:0] nxt1;
  logic [8:0] lo0_sum;
  logic [8:0] hi0_sum;
  logic ovf0;
  logic ovf1;
  logic ovf_hi0;
  logic set0;
  logic set1;

  // Write strobes per register.
  logic wr_mode;
  logic wr_run;
  logic wr_lo0;
  logic wr_hi0;
  logic wr_lo1;
  logic wr_hi1;

  assign wr_mode = reg_wr && (reg_addr == dtc_pkg::MODE_CFG_OFS);
  assign wr_run = reg_wr && (reg_addr == dtc_pkg::RUN_FLAG_OFS);
  assign wr_lo0 = reg_wr && (reg_addr == dtc_pkg::LOW0_OFS);
  assign wr_hi0 = reg_wr && (reg_addr == dtc_pkg::HIGH0_OFS);
  assign wr_lo1 = reg_wr && (reg_addr == dtc_pkg::LOW1_OFS);
  assign wr_hi1 = reg_wr && (reg_addr == dtc_pkg::HIGH1_OFS);

  // Field decode: unit 1 in the high nibble, unit 0 in the low one.
  assign gate1 = mode_cfg_q[dtc_pkg::UNIT1_BASE + dtc_pkg::GATE_BIT]; // [R8] [R23]
  assign gate0 = mode_cfg_q[dtc_pkg::UNIT0_BASE + dtc_pkg::GATE_BIT]; // [R8] [R23]
  assign src1 = mode_cfg_q[dtc_pkg::UNIT1_BASE + dtc_pkg::SRC_BIT]; // [R23]
  assign src0 = mode_cfg_q[dtc_pkg::UNIT0_BASE + dtc_pkg::SRC_BIT]; // [R23]
  assign mode1 = {mode_cfg_q[dtc_pkg::UNIT1_BASE + dtc_pkg::MODE_HI_BIT],
                  mode_cfg_q[dtc_pkg::UNIT1_BASE + dtc_pkg::MODE_LO_BIT]}; // [R3]
  assign mode0 = {mode_cfg_q[dtc_pkg::UNIT0_BASE + dtc_pkg::MODE_HI_BIT],
                  mode_cfg_q[dtc_pkg::UNIT0_BASE + dtc_pkg::MODE_LO_BIT]}; // [R3]
  assign split0 = (mode0 == dtc_pkg::MODE_SPLIT);

  // The divider wraps after MC_DIV clocks, one tick per machine cycle.
  // All counting, pin sampling included, waits for this tick, so a longer
  // divider slows the timers and the pin rate limit alike.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mc_cnt_q <= 8'h00;
    end else if (mc_cnt_q == 8'(MC_DIV - 1)) begin
      mc_cnt_q <= 8'h00; // [R19]
    end else begin
      mc_cnt_q <= mc_cnt_q + 8'h01;
    end
  end
  assign mc_tick = (mc_cnt_q == 8'(MC_DIV - 1)); // [R19]

  // Pins come from outside, so each passes two flops before use.
  // Order is {gate1, gate0, count1, count0}.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
    end else begin
      pin_s1_q <= {gate_pin_unit1, gate_pin_unit0, count_pin_unit1, count_pin_unit0};
      pin_s2_q <= pin_s1_q;
    end
  end

  // The count pins are sampled once per machine cycle; a high sample
  // followed by a low one is a falling edge. A level shorter than one
  // machine cycle may be missed, which is why the source must hold it.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_prev_q <= 2'h0;
    end else if (mc_tick) begin
      cnt_prev_q <= pin_s2_q[1:0]; // [R20]
    end
  end
  assign fall = cnt_prev_q & ~pin_s2_q[1:0] & {2{mc_tick}}; // [R20]

  // Unit 0 counts when run and gate allow, from pin or machine cycle.
  assign inc0 = run0_q && (!gate0 || pin_s2_q[2])
                && (src0 ? fall[0] : mc_tick); // [R1] [R2] [R22]
  // Unit 1 loses its run bit to the high byte of unit 0 in split mode,
  // so then only its gate or its own mode 3 can stop it.
  assign inc1 = (split0 || run1_q) && (!gate1 || pin_s2_q[3])
                && (src1 ? fall[1] : mc_tick); // [R1] [R2] [R16]
  // Split high byte counts machine cycles under unit 1's run bit.
  assign inc_hi0 = split0 && run1_q && mc_tick; // [R15]

  // Next values of both units.
  assign nxt0 = step(mode0, hi0_q, lo0_q);
  assign nxt1 = step(mode1, hi1_q, lo1_q);
  assign lo0_sum = {1'b0, lo0_q} + 9'h001;
  assign hi0_sum = {1'b0, hi0_q} + 9'h001;

  // Overflow events, only when a count step actually happens.
  assign ovf0 = inc0 && (split0 ? lo0_sum[8] : nxt0[16]); // [R14]
  assign ovf1 = inc1 && nxt1[16];
  assign ovf_hi0 = inc_hi0 && hi0_sum[8];
  // Unit 1's flag belongs to the split high byte while unit 0 is split.
  assign set0 = ovf0; // [R9]
  assign set1 = split0 ? ovf_hi0 : ovf1; // [R15] [R17]

  // Mode configuration register, cleared by reset.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_cfg_q <= dtc_pkg::MODE_CFG_RST; // [R18]
    end else if (wr_mode) begin
      mode_cfg_q <= reg_wdata;
    end
  end

  // Run bits are pure software state; writing them never touches counts.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      run0_q <= dtc_pkg::RUN_FLAG_RST[dtc_pkg::RUN0_BIT];
      run1_q <= dtc_pkg::RUN_FLAG_RST[dtc_pkg::RUN1_BIT];
    end else if (wr_run) begin
      run0_q <= reg_wdata[dtc_pkg::RUN0_BIT]; // [R22] [R7]
      run1_q <= reg_wdata[dtc_pkg::RUN1_BIT]; // [R22] [R7]
    end
  end

  // Overflow flags: hardware sets, vector acknowledge or software clears.
  // A set in the same cycle as a clear wins so no overflow is lost.
  // The price is that a clear racing an overflow seems to be ignored.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flag0_q <= dtc_pkg::RUN_FLAG_RST[dtc_pkg::FLAG0_BIT];
    end else if (set0) begin
      flag0_q <= 1'b1; // [R21]
    end else if (irq_ack_unit0) begin
      flag0_q <= 1'b0; // [R21]
    end else if (wr_run) begin
      flag0_q <= reg_wdata[dtc_pkg::FLAG0_BIT];
    end
  end

  // Unit 1 flag, same priority as unit 0.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flag1_q <= dtc_pkg::RUN_FLAG_RST[dtc_pkg::FLAG1_BIT];
    end else if (set1) begin
      flag1_q <= 1'b1; // [R21]
    end else if (irq_ack_unit1) begin
      flag1_q <= 1'b0; // [R21]
    end else if (wr_run) begin
      flag1_q <= reg_wdata[dtc_pkg::FLAG1_BIT];
    end
  end

  // Unit 0 low byte: a software write beats a count in the same cycle.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lo0_q <= dtc_pkg::COUNT_RST;
    end else if (wr_lo0) begin
      lo0_q <= reg_wdata;
    end else if (inc0 && split0) begin
      lo0_q <= lo0_sum[7:0]; // [R14]
    end else if (inc0) begin
      lo0_q <= nxt0[7:0];
    end
  end

  // Unit 0 high byte: cascaded, reload source, or split timer.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hi0_q <= dtc_pkg::COUNT_RST;
    end else if (wr_hi0) begin
      hi0_q <= reg_wdata; // [R12]
    end else if (inc_hi0) begin
      hi0_q <= hi0_sum[7:0]; // [R15]
    end else if (inc0 && !split0) begin
      hi0_q <= nxt0[15:8];
    end
  end

  // Unit 1 count bytes; mode 3 yields no change through the function.
  // In split mode the run bit is ignored here, so the baud overflow keeps
  // coming until its gate stops it or software parks unit 1 in its own mode 3.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lo1_q <= dtc_pkg::COUNT_RST;
      hi1_q <= dtc_pkg::COUNT_RST;
    end else begin
      if (wr_lo1) begin
        lo1_q <= reg_wdata;
      end else if (inc1) begin
        lo1_q <= nxt1[7:0]; // [R13]
      end
      if (wr_hi1) begin
        hi1_q <= reg_wdata; // [R12]
      end else if (inc1) begin
        hi1_q <= nxt1[15:8]; // [R13]
      end
    end
  end

  // Unit 1 overflow pulse for a baud-rate consumer, kept in split mode.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      baud_q <= 1'b0;
    end else begin
      baud_q <= ovf1; // [R17]
    end
  end

  // Read data appears one cycle after the strobe and only then.
  // Unmapped offsets and the external-interrupt bits read as zero.
  // The data are cleared again in the next cycle, so a master that samples
  // late reads zero instead of a stale byte.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        dtc_pkg::MODE_CFG_OFS: begin
          rdata_q <= mode_cfg_q;
        end
        dtc_pkg::RUN_FLAG_OFS: begin
          rdata_q <= {flag1_q, run1_q, flag0_q, run0_q, 4'h0};
        end
        dtc_pkg::LOW0_OFS: begin
          rdata_q <= lo0_q;
        end
        dtc_pkg::HIGH0_OFS: begin
          rdata_q <= hi0_q;
        end
        dtc_pkg::LOW1_OFS: begin
          rdata_q <= lo1_q;
        end
        dtc_pkg::HIGH1_OFS: begin
          rdata_q <= hi1_q;
        end
        default: begin
          rdata_q <= 8'h00;
        end
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // Outputs come straight from flops.
  assign reg_rdata = rdata_q;
  assign irq_req_unit0 = flag0_q; // [R9]
  assign irq_req_unit1 = flag1_q; // [R9]
  assign baud_tick_unit1 = baud_q;

endmodule

// ### verification/dtc_chk.sv
// Port-level checker of the timer block's registers, flags and baud pulse.
`timescale 1ns/100ps
module dtc_chk (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic irq_ack_unit0,
  input wire logic irq_ack_unit1,
  input wire logic irq_req_unit0,
  input wire logic irq_req_unit1,
  input wire logic baud_tick_unit1
);
  logic [7:0] mode_q; // Shadow of the mode register, built from bus writes.
  logic [7:0] run_q; // Shadow of the last run/flag write.
  logic wr_run;
  logic rd_run;
  logic rd_mode;
  assign wr_run = reg_wr && reg_addr == dtc_pkg::RUN_FLAG_OFS;
  assign rd_run = reg_rd && reg_addr == dtc_pkg::RUN_FLAG_OFS;
  assign rd_mode = reg_rd && reg_addr == dtc_pkg::MODE_CFG_OFS;
  // Shadows follow software only, so hardware counting never hides a slip.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_q <= 8'h00;
      run_q <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == dtc_pkg::MODE_CFG_OFS) begin
        mode_q <= reg_wdata;
      end
      if (wr_run) begin
        run_q <= reg_wdata;
      end
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Unit 1 has sat in its own mode 3 for three cycles.
  sequence s_unit1_held;
    mode_q[5:4] == 2'h3 [*3];
  endsequence
  AST_MODE_READBACK: assert property (rd_mode |=> reg_rdata == $past(mode_q))
    else $error("mode register read back wrong");
  AST_FLAG_READBACK: assert property (rd_run |=> reg_rdata[7] == $past(irq_req_unit1)
    && reg_rdata[5] == $past(irq_req_unit0) && reg_rdata[6] == $past(run_q[6]))
    else $error("flag byte disagrees with requests");
  AST_CLR_ONLY_ACK0: assert property ($fell(irq_req_unit0) |->
    $past(irq_ack_unit0) || $past(wr_run)) else $error("flag 0 dropped without cause");
  AST_CLR_ONLY_ACK1: assert property ($fell(irq_req_unit1) |->
    $past(irq_ack_unit1) || $past(wr_run)) else $error("flag 1 dropped without cause");
  AST_RISE_NEEDS_RUN0: assert property ($rose(irq_req_unit0) |->
    $past(run_q[4]) || ($past(wr_run) && $past(reg_wdata[5])))
    else $error("flag 0 set while stopped");
  AST_RISE_NEEDS_RUN1: assert property ($rose(irq_req_unit1) |->
    $past(run_q[6]) || ($past(wr_run) && $past(reg_wdata[7])))
    else $error("flag 1 set while stopped");
  AST_BAUD_PULSE: assert property (baud_tick_unit1 |=> !baud_tick_unit1 [*5])
    else $error("baud pulses closer than a machine cycle");
  AST_UNIT1_HOLD: assert property (s_unit1_held |-> !baud_tick_unit1)
    else $error("unit 1 overflowed while held");
endmodule
bind dtc_top dtc_chk u_chk (.clock(clock), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .irq_ack_unit0(irq_ack_unit0), .irq_ack_unit1(irq_ack_unit1),
  .irq_req_unit0(irq_req_unit0), .irq_req_unit1(irq_req_unit1),
  .baud_tick_unit1(baud_tick_unit1));

// ### verification/dtc_pin_model.sv
// Model of the count and gate pins that face the timers.
`timescale 1ns/100ps
module dtc_pin_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic pulse_en1,
  input wire logic gate_lvl0,
  output logic count_pin_unit0,
  output logic count_pin_unit1,
  output logic gate_pin_unit0,
  output logic gate_pin_unit1
);
  logic [3:0] ph_q; // Phase within one pulse period.
  // Each level stands eight clocks, beyond one machine cycle of six clocks.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ph_q <= 4'h0;
    end else begin
      ph_q <= pulse_en1 ? ph_q + 4'h1 : 4'h0;
    end
  end
  // Pins idle high, as a pulled-up port pin would.
  assign count_pin_unit1 = ~(pulse_en1 & ph_q[3]);
  assign count_pin_unit0 = 1'b1;
  assign gate_pin_unit0 = gate_lvl0;
  assign gate_pin_unit1 = 1'b1;
endmodule

// ### verification/dual_timer_counter_modes_tb.sv
// Self-checking bench for the dual timer/counter.
`timescale 1ns/100ps
module dual_timer_counter_modes_tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ack0 = 1'b0;
  logic ack1 = 1'b0;
  logic pulse_en1 = 1'b0;
  logic gate0 = 1'b1;
  logic [7:0] rdata;
  logic irq0;
  logic irq1;
  logic cp0;
  logic cp1;
  logic gp0;
  logic gp1;
  logic [7:0] d;
  logic baud;
  int baud_n = 0;
  int n0 = 0;
  int mismatches = 0;
  int tests_run = 0;
  always #12.5 clock = ~clock;
  dtc_pin_model pins (.clock(clock), .rst(rst), .pulse_en1(pulse_en1), .gate_lvl0(gate0),
    .count_pin_unit0(cp0), .count_pin_unit1(cp1), .gate_pin_unit0(gp0), .gate_pin_unit1(gp1));
  dtc_top uut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .count_pin_unit0(cp0),
    .count_pin_unit1(cp1), .gate_pin_unit0(gp0), .gate_pin_unit1(gp1),
    .irq_ack_unit0(ack0), .irq_ack_unit1(ack1), .irq_req_unit0(irq0),
    .irq_req_unit1(irq1), .baud_tick_unit1(baud));
  // Counts unit 1 overflow pulses seen at the baud output.
  always @(posedge clock) begin
    if (baud === 1'b1) begin
      baud_n++;
    end
  end
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  // Bounded wait for a unit's request, then confirm it.
  task automatic wait_irq(input bit u, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(posedge clock);
      #1;
      if ((u ? irq1 : irq0) === 1'b1) break;
    end
    cmp({7'h00, u ? irq1 : irq0}, 8'h01);
  endtask
  task automatic ack(input bit u);
    @(posedge clock);
    ack0 <= ~u;
    ack1 <= u;
    @(posedge clock);
    ack0 <= 1'b0;
    ack1 <= 1'b0;
    @(posedge clock);
    #1;
    cmp({6'h00, irq1, irq0}, 8'h00);
  endtask
  task automatic tally_and_finish;
    $display("tests_run %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // A full run takes about 400 cycles; the limit of 8000 cycles leaves ample margin.
  initial begin
    #200000;
    mismatches++;
    tally_and_finish;
  end
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rd(8'h89, d);
    cmp(d, 8'h00);
    wr(8'h89, 8'hA5);
    rd(8'h89, d);
    cmp(d, 8'hA5);
    $display("test registers done");
    wr(8'h8C, 8'hFF);
    wr(8'h8A, 8'hFE);
    wr(8'h89, 8'h01);
    wr(8'h88, 8'h10);
    wait_irq(1'b0, 40);
    wr(8'h88, 8'h20);
    rd(8'h8C, d);
    cmp(d, 8'h00);
    rd(8'h8A, d);
    cmp(d, 8'h00);
    ack(1'b0);
    $display("test mode 1 done");
    gate0 <= 1'b0;
    wr(8'h8C, 8'hF0);
    wr(8'h8A, 8'hFE);
    wr(8'h89, 8'h0A);
    wr(8'h88, 8'h10);
    repeat (60) @(posedge clock);
    rd(8'h8A, d);
    cmp(d, 8'hFE);
    gate0 <= 1'b1;
    wait_irq(1'b0, 60);
    wr(8'h88, 8'h20);
    rd(8'h8C, d);
    cmp(d, 8'hF0);
    rd(8'h8A, d);
    cmp(d, 8'hF0);
    ack(1'b0);
    $display("test reload done");
    wr(8'h8D, 8'hFF);
    wr(8'h8B, 8'h1E);
    wr(8'h89, 8'h00);
    wr(8'h88, 8'h40);
    wait_irq(1'b1, 40);
    wr(8'h88, 8'h80);
    rd(8'h8D, d);
    cmp(d, 8'h00);
    rd(8'h8B, d);
    cmp(d & 8'h1F, 8'h00);
    ack(1'b1);
    $display("test mode 0 done");
    wr(8'h8B, 8'hFE);
    wr(8'h8D, 8'hFF);
    wr(8'h89, 8'h50);
    wr(8'h88, 8'h40);
    repeat (100) @(posedge clock);
    cmp({7'h00, irq1}, 8'h00);
    pulse_en1 <= 1'b1;
    wait_irq(1'b1, 120);
    pulse_en1 <= 1'b0;
    wr(8'h88, 8'h80);
    ack(1'b1);
    $display("test pin counting done");
    // Unit 0 split, unit 1 in reload mode with its run bit clear: one
    // overflow per machine cycle reaches the baud output, none the flag.
    wr(8'h8D, 8'hFF);
    wr(8'h8B, 8'hFF);
    wr(8'h89, 8'h23);
    n0 = baud_n;
    repeat (60) @(posedge clock);
    cmp({7'h00, (baud_n - n0) inside {[9:11]}}, 8'h01);
    cmp({7'h00, irq1}, 8'h00);
    $display("test baud done");
    wr(8'h8C, 8'hFE);
    wr(8'h89, 8'h33);
    wr(8'h88, 8'h40);
    wait_irq(1'b1, 40);
    cmp({7'h00, irq0}, 8'h00);
    rd(8'h8B, d);
    cmp(d, 8'hFF);
    wr(8'h88, 8'h00);
    $display("test split done");
    tally_and_finish;
  end
endmodule
